/* test_tpcr_port_config_regs.sv */
`timescale 1ns/1ps
`include "tpcr_defs.vh"
module test_tpcr_port_config_regs;
    logic       clk, reset, scl_low, sda_low, lane_zero_in, lane_one_in, lane_two_in;
    logic [3:0] clk_activity_in;
    logic [1:0] sel_channel;
    wire        scl_in, sda_in, sda_out, sda_oe, lane_zero_out, lane_one_out, lane_two_out;
    wire        act_detect_en, act_mode_cm, clk_hyst_en, clk_hyst_20mv, data_hyst_en;
    wire        term_cal_run, clk_out_en, data_out_en, data_invert;
    wire  [3:0] clk_term_en, clk_term_100, data_term_en, data_term_100;
    wire  [3:0] data_tx_current, data_preemph, clk_tx_preemph;
    integer     fails, n_tests;
    assign scl_in = !scl_low;
    assign sda_in = !(sda_low || (sda_oe && !sda_out));
    tpcr_port_config_regs #(.POR_CAL_CYCLES(16)) u_tpcr_port_config_regs (.*);
    tpcr_host_model u_tpcr_host_model (.clk, .sda(sda_in), .scl_low, .sda_low);
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
        logic ok;
        u_tpcr_host_model.wr(ptr, val, ok);
        check("write ack", 8'h01, {7'h00, ok});
    endtask
    task automatic rd_check(input string what, input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] got;
        logic       ok;
        u_tpcr_host_model.rd(ptr, got, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check(what, exp, got);
    endtask
    task automatic t_reset();
        check("cal running", 8'h01, {7'h00, term_cal_run});
        repeat (24) @(posedge clk);
        check("cal done", 8'h00, {7'h00, term_cal_run});
        rd_check("ic reset", `TPCR_ADDR_INPUT_CTRL, 8'h12);
        rd_check("tc reset", `TPCR_ADDR_TERM_CTRL, 8'h00);
        rd_check("oo reset", `TPCR_ADDR_OUT_OPTIONS, 8'h00);
        rd_check("dd reset", `TPCR_ADDR_DATA_DRIVE, 8'h00);
    endtask
    task automatic t_input_ctrl();
        logic [7:0] v;
        logic [3:0] oh;
        oh = 4'h4;
        sel_channel <= 2'h2;
        // Each bit alone, then 0x62; recal bit stays set until the next write
        for (int b = 0; b < 9; b++) begin
            v = (b == 8) ? 8'h62 : (8'h01 << b);
            wr(`TPCR_ADDR_INPUT_CTRL, v);
            rd_check("ic", `TPCR_ADDR_INPUT_CTRL, v);
            check("clk term", {4'h0, (oh & {4{~v[2]}}) | (~oh & {4{~v[0]}})}, {4'h0, clk_term_en});
            check("data term", {4'h0, (oh & {4{~v[3]}}) | (~oh & {4{~v[1]}})}, {4'h0, data_term_en});
            check("activity", {6'h00, ~v[0], v[4]}, {6'h00, act_detect_en, act_mode_cm});
            check("hyst", {5'h00, v[5], v[6], 1'b0}, {5'h00, clk_hyst_en, clk_hyst_20mv, data_hyst_en});
            check("recal", {7'h00, v[7]}, {7'h00, term_cal_run});
        end
    endtask
    task automatic t_term();
        wr(`TPCR_ADDR_TERM_CTRL, 8'hA5);
        rd_check("tc", `TPCR_ADDR_TERM_CTRL, 8'hA5);
        check("term 100", 8'hA5, {clk_term_100, data_term_100});
    endtask
    task automatic t_out_opts();
        lane_zero_in <= 1'b1;
        wr(`TPCR_ADDR_OUT_OPTIONS, 8'hFF);
        rd_check("oo upper", `TPCR_ADDR_OUT_OPTIONS, 8'h0F);
        check("out en off", 8'h00, {6'h00, clk_out_en, data_out_en});
        check("lanes inv swap", 8'h06, {5'h00, lane_zero_out, lane_one_out, lane_two_out});
        wr(`TPCR_ADDR_OUT_OPTIONS, 8'h08);
        check("out en on", 8'h03, {6'h00, clk_out_en, data_out_en});
        check("lanes swap", 8'h01, {5'h00, lane_zero_out, lane_one_out, lane_two_out});
    endtask
    task automatic t_drive();
        wr(`TPCR_ADDR_DATA_DRIVE, 8'h8F);
        rd_check("dd", `TPCR_ADDR_DATA_DRIVE, 8'h8F);
        check("drive", 8'h8F, {data_preemph, data_tx_current});
        check("clk preemph", 8'h00, {4'h0, clk_tx_preemph});
    endtask
    task automatic t_activity();
        clk_activity_in <= 4'hA;
        wr(`TPCR_ADDR_ACTIVITY, 8'hFF);
        rd_check("activity", `TPCR_ADDR_ACTIVITY, 8'h0A);
        wr(`TPCR_ADDR_INPUT_CTRL, 8'h63);
        rd_check("act off", `TPCR_ADDR_ACTIVITY, 8'h00);
        rd_check("unmapped", 8'h07, 8'h00);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (80000) @(posedge clk);
        fails = fails + 1;
        end_of_test();
    end
    initial begin
        fails = 0;
        n_tests = 0;
        reset = 1'b1;
        clk_activity_in = 4'h0;
        sel_channel = 2'h0;
        {lane_zero_in, lane_one_in, lane_two_in} = 3'h0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        t_reset();
        t_input_ctrl();
        t_term();
        t_out_opts();
        t_drive();
        t_activity();
        end_of_test();
    end
endmodule // test_tpcr_port_config_regs

/* tpcr_defs.vh */
`ifndef TPCR_DEFS_VH
`define TPCR_DEFS_VH

// Register offsets
`define TPCR_ADDR_ACTIVITY      8'h01
`define TPCR_ADDR_INPUT_CTRL    8'h03
`define TPCR_ADDR_TERM_CTRL     8'h04
`define TPCR_ADDR_OUT_OPTIONS   8'h05
`define TPCR_ADDR_DATA_DRIVE    8'h06

// Reset values
`define TPCR_RST_INPUT_CTRL     8'h12
`define TPCR_RST_TERM_CTRL      8'h00
`define TPCR_RST_OUT_OPTIONS    4'h0
`define TPCR_RST_DATA_DRIVE     8'h00
`define TPCR_READ_ZERO          8'h00

// Input control fields
`define TPCR_IC_TRI_UNSEL_CLK   0
`define TPCR_IC_TRI_UNSEL_DATA  1
`define TPCR_IC_TRI_SEL_CLK     2
`define TPCR_IC_TRI_SEL_DATA    3
`define TPCR_IC_ACT_MODE        4
`define TPCR_IC_HYST_EN         5
`define TPCR_IC_HYST_MAG        6
`define TPCR_IC_RECAL           7

// Termination control fields
`define TPCR_TC_DATA_LSB        0
`define TPCR_TC_CLK_LSB         4

// Output options fields
`define TPCR_OO_TRI_CLK         0
`define TPCR_OO_TRI_DATA        1
`define TPCR_OO_INVERT          2
`define TPCR_OO_SWAP            3
`define TPCR_OO_MSB             3

// Data drive fields
`define TPCR_DD_CUR_MSB         3
`define TPCR_DD_CUR_LSB         0
`define TPCR_DD_PRE_MSB         7
`define TPCR_DD_PRE_LSB         4

// Serial target address, arbitrary value
`define TPCR_DEV_ADDR           7'h2C

// Timing
`define TPCR_CLK_PERIOD_NS      10
`define TPCR_POR_CAL_NS         100000
`define TPCR_POR_CAL_CYC        (`TPCR_POR_CAL_NS / `TPCR_CLK_PERIOD_NS)
`define TPCR_POR_CNT_W          20

// Serial engine
`define TPCR_BITS_PER_BYTE      4'h8
`define TPCR_CNT_ZERO           4'h0
`define TPCR_CNT_ONE            4'h1
`define TPCR_PTR_ONE            8'h01

`define TPCR_NUM_CH             4
`define TPCR_SYNC_W             6

`endif

/* tpcr_host_model.sv */
`timescale 1ns/1ps
`include "tpcr_defs.vh"
module tpcr_host_model #(
    parameter HALF = 8
) (
    input  logic clk,     // Clock
    input  logic sda,     // Resolved data line
    output logic scl_low, // Pull clock line low
    output logic sda_low  // Pull data line low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic bit_io(input logic b, output logic got);
        // Data moves only well after the clock fall
        repeat (2) @(posedge clk);
        sda_low <= !b;
        repeat (HALF) @(posedge clk);
        scl_low <= 1'b0;
        repeat (HALF) @(posedge clk);
        got = sda;
        scl_low <= 1'b1;
    endtask
    task automatic start();
        repeat (2) @(posedge clk);
        sda_low <= 1'b0;
        repeat (HALF) @(posedge clk);
        scl_low <= 1'b0;
        repeat (HALF) @(posedge clk);
        sda_low <= 1'b1;
        repeat (HALF) @(posedge clk);
        scl_low <= 1'b1;
    endtask
    task automatic stop();
        repeat (2) @(posedge clk);
        sda_low <= 1'b1;
        repeat (HALF) @(posedge clk);
        scl_low <= 1'b0;
        repeat (HALF) @(posedge clk);
        sda_low <= 1'b0;
        repeat (HALF) @(posedge clk);
    endtask
    task automatic send8(input logic [7:0] v, inout logic ok);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(v[i], g);
        bit_io(1'b1, g);
        ok = ok & !g;
    endtask
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        ok = 1'b1;
        start();
        send8({`TPCR_DEV_ADDR, 1'b0}, ok);
        send8(ptr, ok);
        send8(d, ok);
        stop();
    endtask
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
        logic g;
        ok = 1'b1;
        start();
        send8({`TPCR_DEV_ADDR, 1'b0}, ok);
        send8(ptr, ok);
        start();
        send8({`TPCR_DEV_ADDR, 1'b1}, ok);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, g);
        stop();
    endtask
endmodule // tpcr_host_model

/* tpcr_port_config_monitor.sv */
`timescale 1ns/1ps
`include "tpcr_defs.vh"
module tpcr_port_config_monitor #(
    parameter [`TPCR_POR_CNT_W-1:0] POR_CAL_CYCLES = `TPCR_POR_CAL_CYC
) (
    input logic       clk,             // Clock
    input logic       reset,           // Reset
    input logic       scl_in,          // Serial clock
    input logic [1:0] sel_channel,     // Selected channel
    input logic       lane_zero_in,    // Lane 0 in
    input logic       lane_one_in,     // Lane 1 in
    input logic       lane_two_in,     // Lane 2 in
    input logic       lane_zero_out,   // Lane 0 out
    input logic       lane_one_out,    // Lane 1 out
    input logic       lane_two_out,    // Lane 2 out
    input logic [3:0] clk_term_en,     // Clock termination
    input logic [3:0] data_term_en,    // Data termination
    input logic       act_detect_en,   // Activity detect
    input logic       act_mode_cm,     // Common-mode detect
    input logic       clk_hyst_en,     // Hysteresis
    input logic       data_hyst_en,    // Data hysteresis
    input logic       term_cal_run,    // Calibrating
    input logic       clk_out_en,      // Clock drivers on
    input logic       data_out_en,     // Data drivers on
    input logic       data_invert,     // Data inverted
    input logic [3:0] data_tx_current, // Current code
    input logic [3:0] data_preemph,    // Pre-emphasis code
    input logic [3:0] clk_tx_preemph   // Clock pre-emphasis
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire  [3:0]                unsel = ~(4'h1 << sel_channel);
    reg   [`TPCR_POR_CNT_W-1:0] since_reg;
    // Cycles since reset release, saturating
    always @(posedge clk) begin
        if (reset) since_reg <= '0;
        else if (since_reg < POR_CAL_CYCLES) since_reg <= since_reg + 1'b1;
    end
    a_unsel_clk_term: assert property ((clk_term_en & unsel) == ({4{act_detect_en}} & unsel))
        else $error("unselected clock termination wrong");
    a_unsel_data_term: assert property (((data_term_en & unsel) == 4'h0)
        || ((data_term_en & unsel) == unsel))
        else $error("unselected data termination mixed");
    a_no_data_extras: assert property (!data_hyst_en && clk_tx_preemph == 4'h0)
        else $error("data hysteresis or clock pre-emphasis on");
    a_reset_defaults: assert property ($fell(reset) |-> act_mode_cm && act_detect_en
        && !clk_hyst_en && clk_out_en && data_out_en && !data_invert
        && {data_preemph, data_tx_current} == 8'h00 && (data_term_en & unsel) == 4'h0)
        else $error("outputs after reset not default");
    a_lane_one_keep: assert property (!$past(reset) |->
        lane_one_out == ($past(lane_one_in) ^ $past(data_invert)))
        else $error("lane one output wrong");
    a_lane_pair_swap: assert property (!$past(reset) |->
        ({lane_zero_out, lane_two_out} ^ {2{$past(data_invert)}}) == {$past(lane_zero_in), $past(lane_two_in)}
        || ({lane_zero_out, lane_two_out} ^ {2{$past(data_invert)}}) == {$past(lane_two_in), $past(lane_zero_in)})
        else $error("lanes zero and two wrong");
    a_por_cal_busy: assert property (since_reg < POR_CAL_CYCLES - 1'b1 |-> term_cal_run)
        else $error("power-on calibration ended early");
    a_cfg_scl_low: assert property ($changed({data_tx_current, data_preemph, data_invert,
        clk_out_en, data_out_en, clk_hyst_en, act_mode_cm}) |-> !scl_in)
        else $error("configuration changed outside a byte end");
endmodule // tpcr_port_config_monitor

bind tpcr_port_config_regs tpcr_port_config_monitor #(.POR_CAL_CYCLES(POR_CAL_CYCLES))
    u_tpcr_port_config_monitor (.*);

/* tpcr_port_config_regs.v */
// Contract
// - Input control bit 0 unterminates unselected clock inputs and disables activity detect.
// - Input control bit 1 puts unselected data inputs in high impedance.
// - Input control bit 2 leaves selected clock inputs unterminated.
// - Input control bit 3 leaves selected data inputs unterminated.
// - Input control bit 4 picks activity mode: 0 AC toggle, 1 common mode.
// - Input control resets to 0x12; host should rewrite it to 0x62.
// - Input control bit 5 enables hysteresis on clock receivers only.
// - Input control bit 6 picks hysteresis: 0 is 10 mV, 1 is 20 mV.
// - Device calibrates termination by itself after power-on.
// - Termination bits 3:0 pick 50 or 100 ohm data termination, A to D.
// - Termination bits 7:4 pick 50 or 100 ohm clock termination, A to D.
// - Output options bit 0 puts clock output drivers in high impedance.
// - Output options bit 1 puts data output drivers in high impedance.
// - Output options bit 2 swaps legs of data pairs; clock pair unchanged.
// - Output options bit 3 exchanges lanes zero and two; lane one stays.
// - Drive bits 3:0 set data current 10 mA plus 0.125 mA steps.
// - Drive bits 7:4 add first-half-bit pre-emphasis to data lanes only.
// - Termination, output options and drive registers reset to zero.
// - Read-only activity register shows detected clock per channel A to D.
`timescale 1ns/1ps
`include "tpcr_defs.vh"

module tpcr_port_config_regs #(
    parameter [`TPCR_POR_CNT_W-1:0] POR_CAL_CYCLES = `TPCR_POR_CAL_CYC
) (
    input  wire        clk,             // 100 MHz serial-interface clock
    input  wire        reset,           // Power-on reset, sync, active high
    input  wire        scl_in,          // Serial clock pin
    input  wire        sda_in,          // Serial data pin level
    output wire        sda_out,         // Serial data drive value, always low
    output reg         sda_oe,          // High while pulling serial data low
    input  wire [3:0]  clk_activity_in, // Raw clock activity per channel A..D
    input  wire [1:0]  sel_channel,     // Currently selected channel
    input  wire        lane_zero_in,    // Recovered lane 0 data bit
    input  wire        lane_one_in,     // Recovered lane 1 data bit
    input  wire        lane_two_in,     // Recovered lane 2 data bit
    output reg         lane_zero_out,   // Lane 0 output bit
    output reg         lane_one_out,    // Lane 1 output bit
    output reg         lane_two_out,    // Lane 2 output bit
    output wire [3:0]  clk_term_en,     // Clock input termination on, per channel
    output wire [3:0]  clk_term_100,    // Clock termination 100 ohm when high
    output wire [3:0]  data_term_en,    // Data input termination on, per channel
    output wire [3:0]  data_term_100,   // Data termination 100 ohm when high
    output wire        act_detect_en,   // Activity detection enabled
    output wire        act_mode_cm,     // Common-mode activity detection
    output wire        clk_hyst_en,     // Clock receiver hysteresis enabled
    output wire        clk_hyst_20mv,   // Hysteresis 20 mV when high, else 10 mV
    output wire        data_hyst_en,    // Data receiver hysteresis, always off
    output wire        term_cal_run,    // Termination calibration running
    output wire        clk_out_en,      // Clock output drivers enabled
    output wire        data_out_en,     // Data output drivers enabled
    output wire        data_invert,     // Data pair legs swapped
    output wire [3:0]  data_tx_current, // Data current code, 10 mA + n*0.125 mA
    output wire [3:0]  data_preemph,    // Data pre-emphasis code, n*0.125 mA
    output wire [3:0]  clk_tx_preemph   // Clock pre-emphasis, always zero
);

    reg  [7:0] input_control_reg;
    reg  [7:0] termination_control_reg;
    reg  [`TPCR_OO_MSB:0] output_options_reg;
    reg  [7:0] data_output_drive_reg;

    reg  [`TPCR_POR_CNT_W-1:0] por_cnt_reg;
    reg        por_cal_reg;

    reg  [3:0] state_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] tx_reg;
    reg  [7:0] ptr_reg;
    reg        rw_reg;
    reg        scl_prev_reg;
    reg        sda_prev_reg;

    wire [`TPCR_SYNC_W-1:0] sync_raw;
    wire [`TPCR_SYNC_W-1:0] sync_val;
    wire       scl_s;
    wire       sda_s;
    wire [3:0] act_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_cond;
    wire       stop_cond;
    wire [3:0] activity;
    reg  [7:0] rd_data;

    localparam [3:0] ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ADDR_ACK = 4'h2,
                     ST_PTR = 4'h3, ST_PTR_ACK = 4'h4, ST_WR = 4'h5,
                     ST_WR_ACK = 4'h6, ST_RD = 4'h7, ST_RD_ACK = 4'h8;

    assign sync_raw = {clk_activity_in, sda_in, scl_in};

    tpcr_sync3 #(
        .WIDTH   (`TPCR_SYNC_W),
        .RST_VAL (1'b1)
    ) u_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (sync_raw),
        .sync_out (sync_val)
    );

    assign scl_s = sync_val[0];
    assign sda_s = sync_val[1];
    assign act_s = sync_val[5:2];

    assign scl_rise   = scl_s & ~scl_prev_reg;
    assign scl_fall   = ~scl_s & scl_prev_reg;
    assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    assign sda_out    = 1'b0;

    // Input control decode
    assign act_detect_en = ~input_control_reg[`TPCR_IC_TRI_UNSEL_CLK];
    assign act_mode_cm   = input_control_reg[`TPCR_IC_ACT_MODE];
    assign clk_hyst_en   = input_control_reg[`TPCR_IC_HYST_EN];
    assign data_hyst_en  = 1'b0;
    assign clk_hyst_20mv = input_control_reg[`TPCR_IC_HYST_MAG];
    assign term_cal_run  = por_cal_reg | input_control_reg[`TPCR_IC_RECAL];

    // Activity seen only while detection is enabled
    assign activity = act_s & {`TPCR_NUM_CH{act_detect_en}};

    // Per-channel termination
    genvar ch;
    generate
        for (ch = 0; ch < `TPCR_NUM_CH; ch = ch + 1) begin : g_ch
            wire is_sel;
            assign is_sel = (sel_channel == ch);
            assign clk_term_en[ch] = is_sel ?
                ~input_control_reg[`TPCR_IC_TRI_SEL_CLK] :
                ~input_control_reg[`TPCR_IC_TRI_UNSEL_CLK];
            assign data_term_en[ch] = is_sel ?
                ~input_control_reg[`TPCR_IC_TRI_SEL_DATA] :
                ~input_control_reg[`TPCR_IC_TRI_UNSEL_DATA];
            assign data_term_100[ch] =
                termination_control_reg[`TPCR_TC_DATA_LSB + ch];
            assign clk_term_100[ch] =
                termination_control_reg[`TPCR_TC_CLK_LSB + ch];
        end
    endgenerate

    // Output options and drive
    assign clk_out_en      = ~output_options_reg[`TPCR_OO_TRI_CLK];
    assign data_out_en     = ~output_options_reg[`TPCR_OO_TRI_DATA];
    assign data_invert     = output_options_reg[`TPCR_OO_INVERT];
    assign data_tx_current =
        data_output_drive_reg[`TPCR_DD_CUR_MSB:`TPCR_DD_CUR_LSB];
    assign data_preemph    =
        data_output_drive_reg[`TPCR_DD_PRE_MSB:`TPCR_DD_PRE_LSB];
    assign clk_tx_preemph  = 4'h0;

    // Lane order and data polarity
    always @(posedge clk) begin
        if (reset) begin
            lane_zero_out <= 1'b0;
            lane_one_out  <= 1'b0;
            lane_two_out  <= 1'b0;
        end else begin
            if (output_options_reg[`TPCR_OO_SWAP]) begin
                lane_zero_out <= lane_two_in ^ data_invert;
                lane_two_out  <= lane_zero_in ^ data_invert;
            end else begin
                lane_zero_out <= lane_zero_in ^ data_invert;
                lane_two_out  <= lane_two_in ^ data_invert;
            end
            lane_one_out <= lane_one_in ^ data_invert;
        end
    end

    // Calibration after power-on
    always @(posedge clk) begin
        if (reset) begin
            por_cal_reg <= 1'b1;
            por_cnt_reg <= {`TPCR_POR_CNT_W{1'b0}};
        end else if (por_cal_reg) begin
            if (por_cnt_reg == POR_CAL_CYCLES - 1'b1) begin
                por_cal_reg <= 1'b0;
            end
            por_cnt_reg <= por_cnt_reg + 1'b1;
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        case (ptr_reg)
            `TPCR_ADDR_ACTIVITY:    rd_data = {4'h0, activity};
            `TPCR_ADDR_INPUT_CTRL:  rd_data = input_control_reg;
            `TPCR_ADDR_TERM_CTRL:   rd_data = termination_control_reg;
            `TPCR_ADDR_OUT_OPTIONS: rd_data = {4'h0, output_options_reg};
            `TPCR_ADDR_DATA_DRIVE:  rd_data = data_output_drive_reg;
            default:                rd_data = `TPCR_READ_ZERO;
        endcase
    end

    // Serial target engine and register writes
    always @(posedge clk) begin
        if (reset) begin
            input_control_reg       <= `TPCR_RST_INPUT_CTRL;
            termination_control_reg <= `TPCR_RST_TERM_CTRL;
            output_options_reg      <= `TPCR_RST_OUT_OPTIONS;
            data_output_drive_reg   <= `TPCR_RST_DATA_DRIVE;
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= `TPCR_CNT_ZERO;
            shift_reg    <= 8'h00;
            tx_reg       <= 8'h00;
            ptr_reg      <= 8'h00;
            rw_reg       <= 1'b0;
            sda_oe       <= 1'b0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
            if (start_cond) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= `TPCR_CNT_ZERO;
                sda_oe      <= 1'b0;
            end else if (stop_cond) begin
                state_reg <= ST_IDLE;
                sda_oe    <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_PTR, ST_WR: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + `TPCR_CNT_ONE;
                        end else if (scl_fall && bit_cnt_reg == `TPCR_BITS_PER_BYTE) begin
                            bit_cnt_reg <= `TPCR_CNT_ZERO;
                            if (state_reg == ST_ADDR) begin
                                if (shift_reg[7:1] == `TPCR_DEV_ADDR) begin
                                    rw_reg    <= shift_reg[0];
                                    sda_oe    <= 1'b1;
                                    state_reg <= ST_ADDR_ACK;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else if (state_reg == ST_PTR) begin
                                ptr_reg   <= shift_reg;
                                sda_oe    <= 1'b1;
                                state_reg <= ST_PTR_ACK;
                            end else begin
                                case (ptr_reg)
                                    `TPCR_ADDR_INPUT_CTRL:
                                        input_control_reg <= shift_reg;
                                    `TPCR_ADDR_TERM_CTRL:
                                        termination_control_reg <= shift_reg;
                                    `TPCR_ADDR_OUT_OPTIONS:
                                        output_options_reg <= shift_reg[`TPCR_OO_MSB:0];
                                    `TPCR_ADDR_DATA_DRIVE:
                                        data_output_drive_reg <= shift_reg;
                                    default: ;
                                endcase
                                ptr_reg   <= ptr_reg + `TPCR_PTR_ONE;
                                sda_oe    <= 1'b1;
                                state_reg <= ST_WR_ACK;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (rw_reg) begin
                                tx_reg    <= {rd_data[6:0], 1'b0};
                                sda_oe    <= ~rd_data[7];
                                ptr_reg   <= ptr_reg + `TPCR_PTR_ONE;
                                state_reg <= ST_RD;
                            end else begin
                                sda_oe    <= 1'b0;
                                state_reg <= ST_PTR;
                            end
                        end
                    end
                    ST_PTR_ACK, ST_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe    <= 1'b0;
                            state_reg <= ST_WR;
                        end
                    end
                    ST_RD: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + `TPCR_CNT_ONE;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == `TPCR_BITS_PER_BYTE) begin
                                bit_cnt_reg <= `TPCR_CNT_ZERO;
                                sda_oe      <= 1'b0;
                                state_reg   <= ST_RD_ACK;
                            end else begin
                                sda_oe <= ~tx_reg[7];
                                tx_reg <= {tx_reg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        if (scl_rise && sda_s) begin
                            // Host answered with no-acknowledge
                            state_reg <= ST_IDLE;
                        end else if (scl_fall) begin
                            tx_reg    <= {rd_data[6:0], 1'b0};
                            sda_oe    <= ~rd_data[7];
                            ptr_reg   <= ptr_reg + `TPCR_PTR_ONE;
                            state_reg <= ST_RD;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // tpcr_port_config_regs

/* tpcr_sync3.v */
`timescale 1ns/1ps
`include "tpcr_defs.vh"

module tpcr_sync3 #(
    parameter WIDTH   = 1,
    parameter RST_VAL = 1'b0
) (
    input  wire             clk,      // System clock
    input  wire             reset,    // Synchronous reset, active high
    input  wire [WIDTH-1:0] async_in, // Inputs from outside the domain
    output wire [WIDTH-1:0] sync_out  // Settled values
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg out_reg;
            always @(posedge clk) begin
                if (reset) begin
                    s1_reg  <= RST_VAL;
                    s2_reg  <= RST_VAL;
                    s3_reg  <= RST_VAL;
                    out_reg <= RST_VAL;
                end else begin
                    s1_reg <= async_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // Change counts only once stages two and three agree
                    if (s2_reg == s3_reg) begin
                        out_reg <= s3_reg;
                    end
                end
            end
            assign sync_out[i] = out_reg;
        end
    endgenerate

endmodule // tpcr_sync3
